/* File: sim/cmd_ctrl_model.sv */
// Controller model: command word, chip selects and late parity bit
`timescale 1ns/1ns
`include "cmd_buf_consts.svh"

module cmd_ctrl_model (
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  input  wire logic        cfg_sel_in,
  input  wire logic [27:0] word_in,
  input  wire logic [1:0]  sel_n_in,
  input  wire logic        corrupt_in,
  output logic      [27:0] cmd_out,
  output logic             chip_sel_0_out,
  output logic             chip_sel_1_out,
  output logic             parity_bit_out
);
  logic [27:0] mask;
  logic        parity_ff;

  assign mask = cfg_sel_in ? `CMD_MASK_CFG_B : `CMD_MASK_CFG_A;
  // Lines parked at a defined level in reset, never left floating
  assign cmd_out = srst_in ? 28'h0 : word_in;
  // A select is dropped by the caller for every real command
  assign chip_sel_0_out = sel_n_in[0];
  assign chip_sel_1_out = sel_n_in[1];

  // ------------------------------------------------------------------
  // Even parity over active lines, presented one cycle late
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      parity_ff <= 1'h0;
    end else begin
      parity_ff <= (^(word_in & mask)) ^ corrupt_in;
    end
  end
  assign parity_bit_out = parity_ff;
endmodule : cmd_ctrl_model

/* File: sim/registered_cmd_buffer_parity_tb.sv */
// Testbench for the registered command buffer with parity check
`timescale 1ns/1ns
`include "cmd_buf_consts.svh"

module registered_cmd_buffer_parity_tb;
  logic        clock_in = 1'h0;
  logic        srst     = 1'h1;
  logic        cfg      = 1'h0;
  logic        gate     = 1'h0;
  logic [27:0] word     = 28'h0;
  logic [1:0]  sel_n    = 2'h3;
  logic [3:0]  tc       = 4'h0;
  logic        corrupt  = 1'h0;
  logic        log_rdy  = 1'h0;
  logic [27:0] cmd;
  logic        cs0;
  logic        cs1;
  logic        par;
  logic [27:0] cmd_outputs_out;
  logic        chip_sel_0_out;
  logic        chip_sel_1_out;
  logic        term_ctrl_0_out;
  logic        term_ctrl_1_out;
  logic        clk_en_0_out;
  logic        clk_en_1_out;
  logic        parity_error_n_out;
  logic        parity_error_oe_out;
  logic        low_power_state_out;
  logic        log_wr_ready_out;
  logic        log_valid_out;
  logic [29:0] log_data_out;
  int          n_errors = 0;
  int          compares = 0;

  always #10 clock_in = ~clock_in;

  cmd_ctrl_model u_cmd_ctrl_model (
    .clock_in(clock_in), .srst_in(srst), .cfg_sel_in(cfg),
    .word_in(word), .sel_n_in(sel_n), .corrupt_in(corrupt),
    .cmd_out(cmd), .chip_sel_0_out(cs0), .chip_sel_1_out(cs1),
    .parity_bit_out(par));

  registered_cmd_buffer_parity u_registered_cmd_buffer_parity (
    .clock_in(clock_in), .srst_in(srst), .cfg_sel_in(cfg),
    .select_gate_enable_in(gate), .cmd_inputs_in(cmd),
    .chip_sel_0_in(cs0), .chip_sel_1_in(cs1),
    .term_ctrl_0_in(tc[2]), .term_ctrl_1_in(tc[3]),
    .clk_en_0_in(tc[0]), .clk_en_1_in(tc[1]), .parity_bit_in(par),
    .cmd_outputs_out(cmd_outputs_out),
    .chip_sel_0_out(chip_sel_0_out), .chip_sel_1_out(chip_sel_1_out),
    .term_ctrl_0_out(term_ctrl_0_out), .term_ctrl_1_out(term_ctrl_1_out),
    .clk_en_0_out(clk_en_0_out), .clk_en_1_out(clk_en_1_out),
    .parity_error_n_out(parity_error_n_out),
    .parity_error_oe_out(parity_error_oe_out),
    .low_power_state_out(low_power_state_out),
    .log_wr_ready_out(log_wr_ready_out), .log_valid_out(log_valid_out),
    .log_ready_in(log_rdy), .log_data_out(log_data_out));

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic step(input logic [27:0] w, input logic [1:0] s,
                      input logic g, input logic c,
                      input logic [3:0] t = 4'h0);
    @(posedge clock_in);
    word <= w;
    sel_n <= s;
    gate <= g;
    corrupt <= c;
    tc <= t;
  endtask : step

  // Let the edge's updates land before sampling
  task automatic settle();
    @(posedge clock_in);
    #1;
  endtask : settle

  task automatic wait_clear();
    int k;
    k = 0;
    while (parity_error_oe_out !== 1'h0 && k < 8) begin
      settle();
      k++;
    end
    check(28'(parity_error_oe_out), 28'h0);
  endtask : wait_clear

  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic do_reset();
    step(28'h0, 2'h3, 1'h0, 1'h0);
    srst <= 1'h1;
    repeat (20) @(posedge clock_in);
    #1;
    check(cmd_outputs_out, 28'h0);
    check(28'({chip_sel_0_out, chip_sel_1_out, term_ctrl_0_out,
               term_ctrl_1_out, clk_en_0_out, clk_en_1_out}), 28'h0);
    check(28'({parity_error_oe_out, log_valid_out}), 28'h0);
    check(28'({log_wr_ready_out, parity_error_n_out}), 28'h2);
    @(posedge clock_in);
    srst <= 1'h0;
  endtask : do_reset

  task automatic t_layout(input logic c);
    logic [27:0] m;
    logic [27:0] spare;
    m = c ? `CMD_MASK_CFG_B : `CMD_MASK_CFG_A;
    // One line that only the other layout checks
    spare = c ? 28'h0100000 : 28'h0000020;
    step(28'hFFFFFFF, 2'h2, 1'h1, 1'h0);
    cfg <= c;
    settle();
    check(cmd_outputs_out, m);
    check(28'({chip_sel_1_out, chip_sel_0_out}), 28'h2);
    step(spare, 2'h1, 1'h1, 1'h0);
    settle();
    check(cmd_outputs_out, 28'h0);
    check(28'({chip_sel_1_out, chip_sel_0_out}), 28'h1);
    repeat (3) settle();
    check(28'(parity_error_oe_out), 28'h0);
  endtask : t_layout

  task automatic t_gate();
    step(28'h0000005, 2'h0, 1'h1, 1'h0);
    settle();
    check(cmd_outputs_out, 28'h0000005);
    step(28'hFFFFFFF, 2'h3, 1'h1, 1'h1, 4'hF);
    settle();
    check(cmd_outputs_out, 28'h0000005);
    check(28'({term_ctrl_1_out, term_ctrl_0_out, clk_en_1_out,
               clk_en_0_out}), 28'hF);
    check(28'({chip_sel_1_out, chip_sel_0_out}), 28'h3);
    repeat (3) settle();
    check(28'({parity_error_oe_out, low_power_state_out}), 28'h1);
    check(cmd_outputs_out, 28'h0000005);
    step(28'hFFFFFFF, 2'h3, 1'h0, 1'h0);
    settle();
    check(cmd_outputs_out, `CMD_MASK_CFG_B);
    check(28'({term_ctrl_1_out, clk_en_0_out}), 28'h0);
  endtask : t_gate

  task automatic t_parity();
    step(28'h0000001, 2'h2, 1'h0, 1'h1);
    step(28'h0000003, 2'h2, 1'h0, 1'h0);
    settle();
    check(28'(parity_error_oe_out), 28'h0);
    settle();
    check(28'(parity_error_oe_out), 28'h1);
    check(28'(parity_error_n_out), 28'h0);
    settle();
    check(28'(parity_error_oe_out), 28'h1);
    wait_clear();
  endtask : t_parity

  task automatic t_lowpower();
    step(28'h0000001, 2'h1, 1'h0, 1'h1);
    step(28'h0000003, 2'h3, 1'h1, 1'h0);
    repeat (6) begin
      settle();
    end
    check(28'({parity_error_oe_out, low_power_state_out}), 28'h3);
    step(28'h0000003, 2'h2, 1'h0, 1'h0);
    settle();
    check(28'(parity_error_oe_out), 28'h1);
    repeat (2) settle();
    check(28'(parity_error_oe_out), 28'h1);
    settle();
    check(28'(parity_error_oe_out), 28'h0);
  endtask : t_lowpower

  // Fill the error log past its depth while the reader stalls
  task automatic t_log();
    int cnt;
    cnt = 0;
    for (int i = 1; i <= 34; i++) begin
      step(28'(i) << 16, 2'h2, 1'h0, 1'h1);
    end
    step(28'h0000003, 2'h2, 1'h0, 1'h0);
    repeat (4) settle();
    check(28'(log_wr_ready_out), 28'h0);
    check(log_data_out[27:0], 28'h0010000);
    check(28'(log_data_out[29:28]), 28'h2);
    step(28'h0000003, 2'h2, 1'h0, 1'h0);
    log_rdy <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      #1;
      if (log_valid_out === 1'h1) begin
        check(log_data_out[27:0], 28'(cnt + 1) << 16);
        cnt++;
      end
      @(posedge clock_in);
    end
    check(28'(cnt), 28'h20);
    check(28'(log_valid_out), 28'h0);
  endtask : t_log

  initial begin
    do_reset();
    t_layout(1'h0);
    t_layout(1'h1);
    t_gate();
    t_parity();
    t_lowpower();
    do_reset();
    t_log();
    tally_and_finish();
  end

  // Whole run needs well under 500 cycles
  initial begin
    repeat (3000) @(posedge clock_in);
    n_errors++;
    tally_and_finish();
  end
endmodule : registered_cmd_buffer_parity_tb

/* File: verilog/cmd_buf_consts.svh */
// Constants for the registered command buffer with parity check
`ifndef CMD_BUF_CONSTS_SVH
`define CMD_BUF_CONSTS_SVH

// ----------------------------------------------------------------------
// Widths and log depth
// ----------------------------------------------------------------------
`define CMD_WIDTH        28
`define LOG_DEPTH        32

// ----------------------------------------------------------------------
// Active command bit masks, bit k stands for command line k+1
// ----------------------------------------------------------------------
`define CMD_MASK_CFG_A   28'h0FFF0F5F
`define CMD_MASK_CFG_B   28'h0FAF0FFF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    20
`define ERR_HOLD_CYCLES  2'h2

`endif

/* File: verilog/cmd_buf_pkg.sv */
// Types shared by the registered command buffer files
package cmd_buf_pkg;

  // --------------------------------------------------------------------
  // Unsuspended control lines, one bit per rank
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] chip_sel;
    logic [1:0] term_ctrl;
    logic [1:0] clk_en;
  } ctrl_bits_t;

  // --------------------------------------------------------------------
  // Entry written to the parity error log
  // --------------------------------------------------------------------
  typedef struct packed {
    logic        cfg_sel;
    logic        parity;
    logic [27:0] cmd;
  } err_log_t;

  // --------------------------------------------------------------------
  // Parity error output states, Gray coded
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ERR_IDLE = 2'h0,
    ERR_LOW  = 2'h1,
    ERR_LPM  = 2'h3
  } err_state_t;

endpackage : cmd_buf_pkg

/* File: verilog/cmd_log_fifo.sv */
// Flip-flop FIFO holding parity error log entries
`timescale 1ns/1ns
`include "cmd_buf_consts.svh"

module cmd_log_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = `LOG_DEPTH
) (
  input  wire logic             clock_in,
  input  wire logic             srst_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("cmd_log_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic             full;
  logic             empty;

  assign full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                 (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge clock_in) begin
    if (wr_valid_in && !full) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wr_ptr_ff <= '0;
    end else if (wr_valid_in && !full) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rd_ptr_ff <= '0;
    end else if (rd_ready_in && !empty) begin
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

endmodule : cmd_log_fifo

/* File: verilog/registered_cmd_buffer_parity.sv */
// Registered command buffer with chip-select gating and parity check
`timescale 1ns/1ns
`include "cmd_buf_consts.svh"

module registered_cmd_buffer_parity #(
  parameter int CMD_W     = `CMD_WIDTH,
  parameter int LOG_DEPTH = `LOG_DEPTH
) (
  input  wire logic             clock_in,
  input  wire logic             srst_in,
  input  wire logic             cfg_sel_in,
  input  wire logic             select_gate_enable_in,
  input  wire logic [CMD_W-1:0] cmd_inputs_in,
  input  wire logic             chip_sel_0_in,
  input  wire logic             chip_sel_1_in,
  input  wire logic             term_ctrl_0_in,
  input  wire logic             term_ctrl_1_in,
  input  wire logic             clk_en_0_in,
  input  wire logic             clk_en_1_in,
  input  wire logic             parity_bit_in,
  output logic      [CMD_W-1:0] cmd_outputs_out,
  output logic                  chip_sel_0_out,
  output logic                  chip_sel_1_out,
  output logic                  term_ctrl_0_out,
  output logic                  term_ctrl_1_out,
  output logic                  clk_en_0_out,
  output logic                  clk_en_1_out,
  output logic                  parity_error_n_out,
  output logic                  parity_error_oe_out,
  output logic                  low_power_state_out,
  output logic                  log_wr_ready_out,
  output logic                  log_valid_out,
  input  wire logic             log_ready_in,
  output logic      [CMD_W+1:0] log_data_out
);

  initial begin
    if (CMD_W != `CMD_WIDTH) begin
      $error("registered_cmd_buffer_parity: CMD_W must be 28");
    end
  end

  // --------------------------------------------------------------------
  // Input decode
  // --------------------------------------------------------------------
  logic [CMD_W-1:0] act_mask;
  logic             cs_any;
  logic             gated;

  assign act_mask = cfg_sel_in ? `CMD_MASK_CFG_B : `CMD_MASK_CFG_A;
  assign cs_any   = !chip_sel_0_in || !chip_sel_1_in;
  // Gate enable low lets every crossing through
  assign gated    = select_gate_enable_in && !cs_any;

  // --------------------------------------------------------------------
  // Data path registers
  // --------------------------------------------------------------------
  cmd_buf_pkg::ctrl_bits_t ctrl_ff;
  logic [CMD_W-1:0]        cmd_q_ff;

  // Clock crossing modelled as the rising clock_in edge
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cmd_q_ff <= '0;
    end else if (!gated) begin
      cmd_q_ff <= cmd_inputs_in & act_mask;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ctrl_ff <= '0;
    end else begin
      ctrl_ff.chip_sel  <= {chip_sel_1_in, chip_sel_0_in};
      ctrl_ff.term_ctrl <= {term_ctrl_1_in, term_ctrl_0_in};
      ctrl_ff.clk_en    <= {clk_en_1_in, clk_en_0_in};
    end
  end

  assign cmd_outputs_out = cmd_q_ff;
  assign chip_sel_0_out  = ctrl_ff.chip_sel[0];
  assign chip_sel_1_out  = ctrl_ff.chip_sel[1];
  assign term_ctrl_0_out = ctrl_ff.term_ctrl[0];
  assign term_ctrl_1_out = ctrl_ff.term_ctrl[1];
  assign clk_en_0_out    = ctrl_ff.clk_en[0];
  assign clk_en_1_out    = ctrl_ff.clk_en[1];

  // --------------------------------------------------------------------
  // Parity pipeline
  // --------------------------------------------------------------------
  logic             chk_v_ff;
  logic             chk_xor_ff;
  logic             chk_cfg_ff;
  logic [CMD_W-1:0] chk_cmd_ff;
  logic             pend_v_ff;
  logic             pend_err_ff;
  logic             lpm_ff;

  // Stage 1: partial parity of the word taken on edge n
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      chk_v_ff   <= 1'b0;
      chk_xor_ff <= 1'b0;
      chk_cfg_ff <= 1'b0;
      chk_cmd_ff <= '0;
    end else begin
      chk_v_ff   <= cs_any;
      chk_xor_ff <= ^(cmd_inputs_in & act_mask);
      chk_cfg_ff <= cfg_sel_in;
      chk_cmd_ff <= cmd_inputs_in;
    end
  end

  // Stage 2: parity bit of edge n+1 completes the word of edge n
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pend_v_ff   <= 1'b0;
      pend_err_ff <= 1'b0;
    end else begin
      pend_v_ff   <= chk_v_ff;
      pend_err_ff <= chk_xor_ff ^ parity_bit_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      lpm_ff <= 1'b0;
    end else begin
      lpm_ff <= gated;
    end
  end

  assign low_power_state_out = lpm_ff;

  // --------------------------------------------------------------------
  // Error output latch
  // --------------------------------------------------------------------
  cmd_buf_pkg::err_state_t err_state_ff;
  logic [1:0]              hold_ff;
  logic                    err_ff;

  assign err_ff = (err_state_ff != cmd_buf_pkg::ERR_IDLE);

  // Stage 3 on edge n+2: hold counter keeps the low level long enough
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      err_state_ff <= cmd_buf_pkg::ERR_IDLE;
      hold_ff      <= 2'h0;
    end else begin
      case (err_state_ff)
        cmd_buf_pkg::ERR_IDLE: begin
          if (pend_v_ff && pend_err_ff) begin
            err_state_ff <= cmd_buf_pkg::ERR_LOW;
            hold_ff      <= `ERR_HOLD_CYCLES - 2'h1;
          end
        end
        cmd_buf_pkg::ERR_LOW: begin
          if (lpm_ff) begin
            err_state_ff <= cmd_buf_pkg::ERR_LPM;
          end else if (pend_v_ff && pend_err_ff) begin
            hold_ff <= `ERR_HOLD_CYCLES - 2'h1;
          end else if (pend_v_ff) begin
            if (hold_ff != 2'h0) begin
              hold_ff <= hold_ff - 2'h1;
            end else begin
              err_state_ff <= cmd_buf_pkg::ERR_IDLE;
            end
          end
        end
        cmd_buf_pkg::ERR_LPM: begin
          // Whole low-power span, then a fresh two-cycle hold
          if (!lpm_ff) begin
            err_state_ff <= cmd_buf_pkg::ERR_LOW;
            hold_ff      <= `ERR_HOLD_CYCLES - 2'h1;
          end
        end
        default: begin
          err_state_ff <= cmd_buf_pkg::ERR_IDLE;
          hold_ff      <= 2'h0;
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign parity_error_n_out  = 1'b0;
  assign parity_error_oe_out = err_ff;

  // --------------------------------------------------------------------
  // Error log
  // --------------------------------------------------------------------
  // Entries arriving while full are dropped; the pin still reports them
  cmd_buf_pkg::err_log_t log_entry;
  logic                  log_push;

  assign log_entry.cfg_sel = chk_cfg_ff;
  assign log_entry.parity  = parity_bit_in;
  assign log_entry.cmd     = chk_cmd_ff;
  assign log_push = chk_v_ff && (chk_xor_ff ^ parity_bit_in) && !srst_in;

  cmd_log_fifo #(
    .WIDTH (CMD_W + 2),
    .DEPTH (LOG_DEPTH)
  ) u_log (
    .clock_in     (clock_in),
    .srst_in      (srst_in),
    .wr_valid_in  (log_push),
    .wr_ready_out (log_wr_ready_out),
    .wr_data_in   (log_entry),
    .rd_valid_out (log_valid_out),
    .rd_ready_in  (log_ready_in),
    .rd_data_out  (log_data_out)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  gate_hold_a: assert property (gated |=> $stable(cmd_outputs_out))
    else $error("gated data outputs changed");

  cmd_update_a: assert property (!srst_in && !gated |=>
    cmd_outputs_out == ($past(cmd_inputs_in) & $past(act_mask)))
    else $error("data outputs missed an update");

  ctrl_track_a: assert property (!srst_in |=>
    {chip_sel_1_out, chip_sel_0_out, term_ctrl_1_out, term_ctrl_0_out,
     clk_en_1_out, clk_en_0_out} ==
    $past({chip_sel_1_in, chip_sel_0_in, term_ctrl_1_in,
           term_ctrl_0_in, clk_en_1_in, clk_en_0_in}))
    else $error("control outputs not tracking inputs");

  unused_low_a: assert property (
    (cmd_outputs_out & ~(cfg_sel_in ? `CMD_MASK_CFG_B
                                    : `CMD_MASK_CFG_A)) == '0)
    else $error("inactive output driven high");

  reset_clear_a: assert property (@(posedge clock_in)
    disable iff (1'b0)
    srst_in |=> (cmd_outputs_out == '0) && !chip_sel_0_out &&
                !parity_error_oe_out)
    else $error("reset did not clear outputs");

  parity_delay_a: assert property (
    !$past(srst_in) && $past(cs_any) &&
    (parity_bit_in != $past(^(cmd_inputs_in & act_mask)))
    |-> ##2 parity_error_oe_out)
    else $error("parity error not flagged at n+2");

  parity_ok_a: assert property (
    !cs_any ##2 !parity_error_oe_out |=> !parity_error_oe_out)
    else $error("error raised without chip select");

  err_hold_a: assert property (
    $rose(parity_error_oe_out) |=> parity_error_oe_out)
    else $error("error released before two cycles");

  lpm_hold_a: assert property ((lpm_ff && err_ff) |=> err_ff)
    else $error("latched error lost in low power");

  no_eval_a: assert property (
    (!pend_v_ff && err_state_ff != cmd_buf_pkg::ERR_LPM) |=>
    $stable(err_ff))
    else $error("error changed without a checked word");

  lpm_flag_a: assert property (gated |=> low_power_state_out)
    else $error("low power state not flagged");

  log_flag_a: assert property (log_push |-> ##2 parity_error_oe_out)
    else $error("logged error not on the pin");

  err_quiet_a: assert property (
    (!err_ff && !(pend_v_ff && pend_err_ff)) |=> !err_ff)
    else $error("error raised without a failed word");

  err_seen_c: cover property ($rose(parity_error_oe_out));
  gated_c:    cover property (gated ##1 gated ##1 !gated);
  cfg_b_c:    cover property (cfg_sel_in && $rose(parity_error_oe_out));
  lpm_err_c:  cover property (lpm_ff && err_ff ##1 !lpm_ff);

endmodule : registered_cmd_buffer_parity
